// file: bench/actrim_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module actrim_bank_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire actrim_pkg::actrim_axi_req_s axiReq,
  input wire actrim_pkg::actrim_axi_rsp_s axiRsp,
  input wire actrim_pkg::actrim_fuse_s fuseImage,
  input wire logic core2SelSecondPair,
  input wire logic core3SelFourthPair,
  input wire actrim_pkg::actrim_trim_s trimOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence wrBoth;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence wrFull(logic [11:0] a);
    wrBoth ##0 (axiReq.awaddr == a && axiReq.wstrb == 4'hf);
  endsequence
  chk_fuse_load: assert property ($rose(rstn) |=>
    trimOut.core4Offset == $past(fuseImage.ofs[2][11:0]) &&
    trimOut.core0Gain == $past(fuseImage.gain[0][4:0]))
    else $error("trims not loaded from fuse image");
  chk_core0_fine_gain_trim_write: assert property (wrFull(12'hd80) |=>
    trimOut.core0Gain == $past(axiReq.wdata[4:0]))
    else $error("core0 gain not taken from write");
  chk_core4_write: assert property (wrFull(12'hcf0) |=>
    trimOut.core4Offset == $past(axiReq.wdata[11:0]))
    else $error("core4 offset not taken from write");
  chk_core3_pair: assert property ($past(rstn) |->
    trimOut.core3GainValid == !$past(core3SelFourthPair))
    else $error("core3 gain valid wrong for selected pair");
  chk_read_upper: assert property (axiRsp.rvalid |->
    axiRsp.rdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  chk_read_busy: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read address accepted while answer pending");
  chk_write_busy: assert property (axiRsp.bvalid |->
    !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  chk_unmapped_err: assert property (wrBoth ##0 axiReq.awaddr == 12'h004
    |=> axiRsp.bvalid && axiRsp.bresp == 2'h2)
    else $error("unmapped write not answered with slave error");
endmodule // actrim_bank_asserts
`default_nettype wire

// file: bench/actrim_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module actrim_bank_tb;
  logic clk;
  logic rstn;
  actrim_pkg::actrim_axi_req_s req;
  actrim_pkg::actrim_axi_rsp_s rsp;
  actrim_pkg::actrim_axi_rsp_s s;
  actrim_pkg::actrim_fuse_s fuse;
  logic sel2;
  logic sel3;
  actrim_pkg::actrim_trim_s trim;
  int errTotal;
  int numChecks;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [11:0] addrs [9] = '{12'hce0, 12'hce8, 12'hcf0, 12'hcf8, 12'hd80,
    12'hd84, 12'hd88, 12'hd8c, 12'hd90};
  actrim_bank dut_u (.clk(clk), .rstn(rstn), .axiReq(req), .axiRsp(rsp),
    .fuseImage(fuse), .core2SelSecondPair(sel2), .core3SelFourthPair(sel3),
    .trimOut(trim));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Sampled mid-cycle so handshakes never race the design's own edge
  always @(negedge clk) s = rsp;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s.awready) req.awvalid <= 1'b0;
      if (s.wready) req.wvalid <= 1'b0;
    end while (!s.bvalid);
    req.bready <= 1'b0;
    resp = s.bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s.arready) req.arvalid <= 1'b0;
    end while (!s.rvalid);
    req.rready <= 1'b0;
    rdat = s.rdata;
    resp = s.rresp;
  endtask
  task automatic doReset();
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    chk(trim, 0);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(trim, {12'h111, 12'h333, 12'h444, 5'h11, 5'h12, 5'h13, 5'h15, 1'b1});
  endtask
  initial begin
    req = '0;
    fuse = {16'h0444, 16'h0333, 16'h0222, 16'h0111, 8'h15, 8'h14, 8'h13,
      8'h12, 8'h11};
    sel2 = 1'b0;
    sel3 = 1'b0;
    rstn = 1'b0;
    errTotal = 0;
    numChecks = 0;
    doReset();
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 32'hffff_0a10 + i);
      chk(resp, 0);
      rd(addrs[i]);
      chk(rdat, (32'hffff_0a10 + i) & (i < 4 ? 32'hffff : 32'hff));
    end
    chk(trim, {12'ha10, 12'ha12, 12'ha13, 5'h14, 5'h15, 5'h16, 5'h18, 1'b1});
    sel2 <= 1'b1;
    sel3 <= 1'b1;
    repeat (2) @(posedge clk);
    chk(trim, {12'ha11, 12'ha12, 12'ha13, 5'h14, 5'h15, 5'h17, 5'h18, 1'b0});
    $display("table test done");
    wr(12'h004, 32'h1);
    chk(resp, 2);
    rd(12'hd81);
    chk({rdat, resp}, {32'h0, 2'h2});
    rd(12'hcf0);
    chk(rdat, 32'ha12);
    $display("unmapped test done");
    sel2 <= 1'b0;
    sel3 <= 1'b0;
    doReset();
    rd(12'hcf8);
    chk(rdat, 32'h444);
    $display("second reset test done");
    summarize();
  end
  // About a hundred cycles are expected; far beyond that means a hung handshake
  initial begin
    #40000;
    errTotal++;
    summarize();
  end
endmodule // actrim_bank_tb
bind actrim_bank actrim_bank_asserts chk_u (.clk(clk), .rstn(rstn),
  .axiReq(axiReq), .axiRsp(axiRsp), .fuseImage(fuseImage),
  .core2SelSecondPair(core2SelSecondPair),
  .core3SelFourthPair(core3SelFourthPair), .trimOut(trimOut));
`default_nettype wire

// file: hw/actrim_bank.sv
`timescale 1ns/1ps
`default_nettype none

module actrim_bank (
  input wire logic clk,
  input wire logic rstn,
  input wire actrim_pkg::actrim_axi_req_s axiReq,
  output var actrim_pkg::actrim_axi_rsp_s axiRsp,
  input wire actrim_pkg::actrim_fuse_s fuseImage,
  input wire logic core2SelSecondPair,
  input wire logic core3SelFourthPair,
  output var actrim_pkg::actrim_trim_s trimOut
);

  typedef struct packed {
    actrim_pkg::actrim_phase_e phase;
    logic [actrim_pkg::NUM_OFS-1:0][15:0] ofs;
    logic [actrim_pkg::NUM_GAIN-1:0][7:0] gain;
    logic awHave;
    logic [actrim_pkg::ADDR_W-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    actrim_pkg::actrim_axi_rsp_s rsp;
    actrim_pkg::actrim_trim_s trim;
  } actrim_state_s;

  actrim_state_s state_r;
  actrim_state_s state_nxt;

  // Byte address to bank slot; misaligned or unmapped gives SLOT_NONE
  function automatic logic [3:0] slotOf(
    input logic [actrim_pkg::ADDR_W-1:0] addr
  );
    logic [3:0] s;
    s = actrim_pkg::SLOT_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[actrim_pkg::ADDR_W-1:2])
        actrim_pkg::IDX_CORE3_INPUT_C_OFFSET_TRIM: s = 4'h0;
        actrim_pkg::IDX_CORE3_INPUT_D_OFFSET_TRIM: s = 4'h1;
        actrim_pkg::IDX_CORE4_OFFSET_TRIM: s = 4'h2;
        actrim_pkg::IDX_CORE5_OFFSET_TRIM: s = 4'h3;
        actrim_pkg::IDX_CORE0_FINE_GAIN_TRIM: s = 4'h4;
        actrim_pkg::IDX_CORE1_FINE_GAIN_TRIM: s = 4'h5;
        actrim_pkg::IDX_CORE2_INPUT_A_FINE_GAIN_TRIM: s = 4'h6;
        actrim_pkg::IDX_CORE2_INPUT_B_FINE_GAIN_TRIM: s = 4'h7;
        actrim_pkg::IDX_CORE3_INPUT_C_FINE_GAIN_TRIM: s = 4'h8;
        default: s = actrim_pkg::SLOT_NONE;
      endcase
    end
    return s;
  endfunction

  always_comb begin
    logic [3:0] wSlot;
    logic [3:0] rSlot;
    logic [3:0] gIdx;
    logic running;
    state_nxt = state_r;
    wSlot = actrim_pkg::SLOT_NONE;
    rSlot = actrim_pkg::SLOT_NONE;
    gIdx = 4'h0;
    running = 1'b0;

    unique case (state_r.phase)
      actrim_pkg::ACTRIM_LOAD: begin
        // Fuse image replaces the nominal zero reset value
        state_nxt.ofs = fuseImage.ofs;
        state_nxt.gain = fuseImage.gain;
        state_nxt.phase = actrim_pkg::ACTRIM_RUN;
      end
      actrim_pkg::ACTRIM_RUN: begin
        running = 1'b1;
      end
      default: begin
        state_nxt.phase = actrim_pkg::ACTRIM_LOAD;
      end
    endcase

    // Write address and data are taken independently, in either order
    if (state_r.rsp.awready && axiReq.awvalid) begin
      state_nxt.awHave = 1'b1;
      state_nxt.awAddr = axiReq.awaddr;
    end
    if (state_r.rsp.wready && axiReq.wvalid) begin
      state_nxt.wHave = 1'b1;
      state_nxt.wData = axiReq.wdata;
      state_nxt.wStrb = axiReq.wstrb;
    end
    if (state_r.rsp.bvalid && axiReq.bready) begin
      state_nxt.rsp.bvalid = 1'b0;
    end

    if (state_nxt.awHave && state_nxt.wHave && !state_nxt.rsp.bvalid) begin
      wSlot = slotOf(state_nxt.awAddr);
      // Reserved upper bits are stored as written
      if (wSlot < actrim_pkg::SLOT_FIRST_GAIN) begin
        if (state_nxt.wStrb[0]) begin
          state_nxt.ofs[wSlot[1:0]][7:0] = state_nxt.wData[7:0];
        end
        if (state_nxt.wStrb[1]) begin
          state_nxt.ofs[wSlot[1:0]][15:8] = state_nxt.wData[15:8];
        end
      end else if (wSlot != actrim_pkg::SLOT_NONE) begin
        gIdx = wSlot - actrim_pkg::SLOT_FIRST_GAIN;
        if (state_nxt.wStrb[0]) begin
          state_nxt.gain[gIdx[2:0]] = state_nxt.wData[7:0];
        end
      end
      state_nxt.rsp.bresp = (wSlot == actrim_pkg::SLOT_NONE) ?
        actrim_pkg::RESP_SLVERR : actrim_pkg::RESP_OKAY;
      state_nxt.rsp.bvalid = 1'b1;
      state_nxt.awHave = 1'b0;
      state_nxt.wHave = 1'b0;
    end

    if (state_r.rsp.rvalid && axiReq.rready) begin
      state_nxt.rsp.rvalid = 1'b0;
    end
    // Read only samples storage; the correction outputs never see it
    if (state_r.rsp.arready && axiReq.arvalid) begin
      rSlot = slotOf(axiReq.araddr);
      state_nxt.rsp.rdata = 32'h0000_0000;
      state_nxt.rsp.rresp = actrim_pkg::RESP_OKAY;
      if (rSlot < actrim_pkg::SLOT_FIRST_GAIN) begin
        state_nxt.rsp.rdata[15:0] = state_r.ofs[rSlot[1:0]];
      end else if (rSlot != actrim_pkg::SLOT_NONE) begin
        gIdx = rSlot - actrim_pkg::SLOT_FIRST_GAIN;
        state_nxt.rsp.rdata[7:0] = state_r.gain[gIdx[2:0]];
      end else begin
        state_nxt.rsp.rresp = actrim_pkg::RESP_SLVERR;
      end
      state_nxt.rsp.rvalid = 1'b1;
    end

    // One write and one read in flight; no acceptance while loading fuses
    state_nxt.rsp.awready = running && !state_nxt.awHave &&
      !state_nxt.rsp.bvalid;
    state_nxt.rsp.wready = running && !state_nxt.wHave &&
      !state_nxt.rsp.bvalid;
    state_nxt.rsp.arready = running && !state_nxt.rsp.rvalid;

    // Offsets leave as plain 12-bit unsigned codes, reserved bits dropped
    state_nxt.trim.core3Offset = core3SelFourthPair ?
      state_nxt.ofs[1][actrim_pkg::OFS_FIELD_MSB:0] :
      state_nxt.ofs[0][actrim_pkg::OFS_FIELD_MSB:0];
    state_nxt.trim.core4Offset =
      state_nxt.ofs[2][actrim_pkg::OFS_FIELD_MSB:0];
    state_nxt.trim.core5Offset =
      state_nxt.ofs[3][actrim_pkg::OFS_FIELD_MSB:0];
    state_nxt.trim.core0Gain =
      state_nxt.gain[0][actrim_pkg::GAIN_FIELD_MSB:0];
    state_nxt.trim.core1Gain =
      state_nxt.gain[1][actrim_pkg::GAIN_FIELD_MSB:0];
    state_nxt.trim.core2Gain = core2SelSecondPair ?
      state_nxt.gain[3][actrim_pkg::GAIN_FIELD_MSB:0] :
      state_nxt.gain[2][actrim_pkg::GAIN_FIELD_MSB:0];
    // Fourth-pair gain of core 3 lives outside this bank
    state_nxt.trim.core3Gain =
      state_nxt.gain[4][actrim_pkg::GAIN_FIELD_MSB:0];
    state_nxt.trim.core3GainValid = !core3SelFourthPair;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
      state_r.phase <= actrim_pkg::ACTRIM_LOAD;
      state_r.ofs <= {actrim_pkg::NUM_OFS{actrim_pkg::OFS_RESET}};
      state_r.gain <= {actrim_pkg::NUM_GAIN{actrim_pkg::GAIN_RESET}};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign axiRsp = state_r.rsp;
  assign trimOut = state_r.trim;

endmodule // actrim_bank

`default_nettype wire

// file: hw/actrim_pkg.sv
package actrim_pkg;

  // Printed offsets are register indices; byte address is index times four
  localparam logic [9:0] IDX_CORE3_INPUT_C_OFFSET_TRIM = 10'h338;
  localparam logic [9:0] IDX_CORE3_INPUT_D_OFFSET_TRIM = 10'h33a;
  localparam logic [9:0] IDX_CORE4_OFFSET_TRIM = 10'h33c;
  localparam logic [9:0] IDX_CORE5_OFFSET_TRIM = 10'h33e;
  localparam logic [9:0] IDX_CORE0_FINE_GAIN_TRIM = 10'h360;
  localparam logic [9:0] IDX_CORE1_FINE_GAIN_TRIM = 10'h361;
  localparam logic [9:0] IDX_CORE2_INPUT_A_FINE_GAIN_TRIM = 10'h362;
  localparam logic [9:0] IDX_CORE2_INPUT_B_FINE_GAIN_TRIM = 10'h363;
  localparam logic [9:0] IDX_CORE3_INPUT_C_FINE_GAIN_TRIM = 10'h364;

  localparam int NUM_OFS = 4;
  localparam int NUM_GAIN = 5;
  localparam int ADDR_W = 12;

  // Field layout
  localparam int OFS_FIELD_MSB = 11;
  localparam int GAIN_FIELD_MSB = 4;

  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [7:0] GAIN_RESET = 8'h00;

  // Slot numbering inside the bank
  localparam logic [3:0] SLOT_NONE = 4'hf;
  localparam logic [3:0] SLOT_FIRST_GAIN = 4'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACTRIM_LOAD = 2'h1,
    ACTRIM_RUN = 2'h2
  } actrim_phase_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } actrim_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } actrim_axi_rsp_s;

  // Fuse image: offsets in slot order 0..3, gains in slot order 4..8 as entries 0..4
  typedef struct packed {
    logic [NUM_OFS-1:0][15:0] ofs;
    logic [NUM_GAIN-1:0][7:0] gain;
  } actrim_fuse_s;

  typedef struct packed {
    logic [11:0] core3Offset;
    logic [11:0] core4Offset;
    logic [11:0] core5Offset;
    logic [4:0] core0Gain;
    logic [4:0] core1Gain;
    logic [4:0] core2Gain;
    logic [4:0] core3Gain;
    logic core3GainValid;
  } actrim_trim_s;

endpackage
